// File: rtl/spl_pkg.sv
// constants and types shared by the sector protection lock logic
`default_nettype none
package spl_pkg;
   // ===========================================================
   // command opcodes
   localparam logic [7:0] OP_NONE       = 8'h00;
   localparam logic [7:0] OP_READ_PROT  = 8'h3c;
   localparam logic [7:0] OP_PROTECT    = 8'h36;
   localparam logic [7:0] OP_UNPROTECT  = 8'h39;
   localparam logic [7:0] OP_WRITE_STAT = 8'h01;
   localparam logic [7:0] OP_READ_STAT  = 8'h05;

   // ===========================================================
   // frame bit counts
   localparam int             CNT_W     = 6;
   localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3f;
   localparam logic [CNT_W-1:0] OPC_LAST = 6'h07;
   localparam logic [CNT_W-1:0] ADR_LAST = 6'h1f;
   localparam logic [CNT_W-1:0] WSR_BITS = 6'h10;
   localparam logic [CNT_W-1:0] ADR_BITS = 6'h20;
   localparam int             SHIFT_W   = 32;

   // ===========================================================
   // status byte one layout
   localparam int STAT_LOCK   = 7;
   localparam int STAT_WP     = 4;
   localparam int STAT_SUM_HI = 3;
   localparam int STAT_SUM_LO = 2;
   localparam int GLOB_HI     = 5;
   localparam int GLOB_LO     = 2;
   localparam logic [3:0] GLOB_UNPROT = 4'h0;
   localparam logic [3:0] GLOB_PROT   = 4'hf;
   localparam logic [1:0] SUM_NONE    = 2'h0;
   localparam logic [1:0] SUM_SOME    = 2'h1;
   localparam logic [1:0] SUM_ALL     = 2'h3;

   // ===========================================================
   // reset values and output bytes
   localparam logic       LOCK_RST   = 1'b0;
   localparam logic       PROT_RST   = 1'b1;
   localparam logic [7:0] BYTE_ONES  = 8'hff;
   localparam logic [7:0] BYTE_ZEROS = 8'h00;
   localparam logic [2:0] BIT_MSB    = 3'h7;

   // ===========================================================
   // types
   typedef enum logic [1:0] {SPL_IDLE, SPL_CMD, SPL_OUT_PROT, SPL_OUT_STAT} spl_state_t;

   typedef struct packed {
      logic sck;
      logic cs_n;
      logic si;
      logic wp_n;
   } spl_pins_t;

   localparam spl_pins_t PINS_RST = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1};
endpackage
`default_nettype wire

// File: rtl/spl_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module spl_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // ===========================================================
   // first stage feeds only the second stage
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta_ff <= RST_VAL;
         q_ff    <= RST_VAL;
      end else if (ce_i) begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule
`default_nettype wire

// File: rtl/spl_lock_top.sv
// sector protection read, lock bit and write-protect locking of a serial flash
`default_nettype none
module spl_lock_top
   import spl_pkg::*;
#(
   parameter int SECT_BITS = 4,
   parameter int SECT_LSB  = 16,
   parameter int NUM_SECT  = 1 << SECT_BITS
) (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   input  wire logic                sck_i,
   input  wire logic                cs_n_i,
   input  wire logic                si_i,
   input  wire logic                wp_n_i,
   output logic                     so_o,
   output logic                     so_oe_o,
   output logic [7:0]               status_byte_o,
   output logic [NUM_SECT-1:0]      prot_bits_o,
   output logic                     lock_o,
   output logic                     hw_locked_o
);
   // ===========================================================
   // pin synchronisation and edge detection
   spl_pins_t pins_raw;
   spl_pins_t pins_s;
   logic      sck_d_ff;
   logic      cs_d_ff;
   logic      sck_rise;
   logic      sck_fall;
   logic      cs_rise;

   assign pins_raw = '{sck: sck_i, cs_n: cs_n_i, si: si_i, wp_n: wp_n_i};

   spl_sync #(
      .W       ($bits(spl_pins_t)),
      .RST_VAL (PINS_RST)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .d_i       (pins_raw),
      .q_o       (pins_s)
   );

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sck_d_ff <= PINS_RST.sck;
         cs_d_ff  <= PINS_RST.cs_n;
      end else if (ce_i) begin
         sck_d_ff <= pins_s.sck;
         cs_d_ff  <= pins_s.cs_n;
      end
   end

   assign sck_rise = ce_i & pins_s.sck & ~sck_d_ff;
   assign sck_fall = ce_i & ~pins_s.sck & sck_d_ff;
   assign cs_rise  = ce_i & pins_s.cs_n & ~cs_d_ff;

   // ===========================================================
   // frame state, shifting and opcode capture
   spl_state_t           state_ff;
   logic [CNT_W-1:0]     bit_cnt_ff;
   logic [SHIFT_W-1:0]   shift_ff;
   logic [SHIFT_W-1:0]   nxt_shift;
   logic [7:0]           op_ff;
   logic [SECT_BITS-1:0] sect_ff;

   assign nxt_shift = {shift_ff[SHIFT_W-2:0], pins_s.si};

   // sck must not rise in the cycle after chip select falls; at 120 ns it never does
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_ff <= SPL_IDLE;
      end else if (ce_i) begin
         if (pins_s.cs_n) begin
            state_ff <= SPL_IDLE;
         end else begin
            unique case (state_ff)
               SPL_IDLE: begin
                  state_ff <= SPL_CMD;
               end
               SPL_CMD: begin
                  if (sck_rise && bit_cnt_ff == OPC_LAST && nxt_shift[7:0] == OP_READ_STAT) begin
                     state_ff <= SPL_OUT_STAT;
                  end else if (sck_rise && bit_cnt_ff == ADR_LAST && op_ff == OP_READ_PROT) begin
                     state_ff <= SPL_OUT_PROT;
                  end
               end
               SPL_OUT_PROT: begin
                  state_ff <= SPL_OUT_PROT;
               end
               SPL_OUT_STAT: begin
                  state_ff <= SPL_OUT_STAT;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         bit_cnt_ff <= '0;
         shift_ff   <= '0;
      end else if (ce_i) begin
         if (pins_s.cs_n) begin
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
         end else if (sck_rise && state_ff != SPL_IDLE) begin
            shift_ff <= nxt_shift;
            if (bit_cnt_ff != CNT_MAX) begin
               bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         op_ff   <= OP_NONE;
         sect_ff <= '0;
      end else if (ce_i) begin
         if (pins_s.cs_n) begin
            op_ff <= OP_NONE;
         end else if (sck_rise && state_ff == SPL_CMD && bit_cnt_ff == OPC_LAST) begin
            op_ff <= nxt_shift[7:0];
         end else if (sck_rise && state_ff == SPL_CMD && bit_cnt_ff == ADR_LAST) begin
            sect_ff <= nxt_shift[SECT_LSB +: SECT_BITS];
         end
      end
   end

   // ===========================================================
   // serial output, changed on falling sck
   logic       so_ff;
   logic       so_oe_ff;
   logic [2:0] out_idx_ff;
   logic [7:0] rd_byte;
   logic [7:0] status_ff;
   logic [NUM_SECT-1:0] prot_ff;

   // the protection byte is built from the stored bit alone
   assign rd_byte = (state_ff == SPL_OUT_PROT) ?
                    (prot_ff[sect_ff] ? BYTE_ONES : BYTE_ZEROS) : status_ff;

   // floats a few clocks after the pin rises, because cs passes the synchroniser
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         so_ff      <= 1'b0;
         so_oe_ff   <= 1'b0;
         out_idx_ff <= BIT_MSB;
      end else if (ce_i) begin
         if (pins_s.cs_n) begin
            so_ff      <= 1'b0;
            so_oe_ff   <= 1'b0;
            out_idx_ff <= BIT_MSB;
         end else if (sck_fall && (state_ff == SPL_OUT_PROT || state_ff == SPL_OUT_STAT)) begin
            so_oe_ff   <= 1'b1;
            so_ff      <= rd_byte[out_idx_ff];
            out_idx_ff <= out_idx_ff - 1'b1;
         end
      end
   end

   assign so_o    = so_ff;
   assign so_oe_o = so_oe_ff;

   // ===========================================================
   // protection and lock state, acted on at the end of a frame
   logic                 lock_ff;
   logic                 hw_lock;
   logic                 wsr_go;
   logic                 prot_go;
   logic [7:0]           wsr_data;
   logic [3:0]           glob;
   logic [SECT_BITS-1:0] sect_wr;

   assign hw_lock  = ~pins_s.wp_n & lock_ff;
   assign wsr_go   = cs_rise && op_ff == OP_WRITE_STAT && bit_cnt_ff == WSR_BITS;
   assign prot_go  = cs_rise && (op_ff == OP_PROTECT || op_ff == OP_UNPROTECT)
                     && bit_cnt_ff == ADR_BITS;
   assign wsr_data = shift_ff[7:0];
   assign glob     = wsr_data[GLOB_HI:GLOB_LO];
   assign sect_wr  = shift_ff[SECT_LSB +: SECT_BITS];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lock_ff <= LOCK_RST;
      end else if (wsr_go && !hw_lock) begin
         if (lock_ff) begin
            if (!wsr_data[STAT_LOCK]) begin
               lock_ff <= 1'b0;
            end
         end else begin
            lock_ff <= wsr_data[STAT_LOCK];
         end
      end
   end

   // any nonzero lock bit blocks changes, so the pin only matters through the lock
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prot_ff <= {NUM_SECT{PROT_RST}};
      end else if (wsr_go && !lock_ff) begin
         if (glob == GLOB_UNPROT) begin
            prot_ff <= '0;
         end else if (glob == GLOB_PROT) begin
            prot_ff <= '1;
         end
      end else if (prot_go && !lock_ff) begin
         prot_ff[sect_wr] <= (op_ff == OP_PROTECT);
      end
   end

   // ===========================================================
   // status byte and observation outputs
   logic [7:0] nxt_status;
   logic [1:0] summary;
   logic       hw_locked_ff;

   assign summary = (&prot_ff) ? SUM_ALL : ((|prot_ff) ? SUM_SOME : SUM_NONE);

   always_comb begin
      nxt_status                          = '0;
      nxt_status[STAT_LOCK]               = lock_ff;
      nxt_status[STAT_WP]                 = pins_s.wp_n;
      nxt_status[STAT_SUM_HI:STAT_SUM_LO] = summary;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         status_ff    <= '0;
         hw_locked_ff <= 1'b0;
      end else if (ce_i) begin
         status_ff    <= nxt_status;
         hw_locked_ff <= hw_lock;
      end
   end

   assign status_byte_o = status_ff;
   assign hw_locked_o   = hw_locked_ff;
   assign lock_o        = lock_ff;
   assign prot_bits_o   = prot_ff;

   // ===========================================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   so_float_a: assert property (ce_i && pins_s.cs_n |=> !so_oe_o)
      else $error("serial output still driven after chip select rose");

   prot_byte_a: assert property (state_ff == SPL_OUT_PROT && so_oe_ff
                                 |-> so_ff == prot_ff[sect_ff])
      else $error("protection read bit differs from stored bit");

   no_pin_a: assert property (state_ff == SPL_OUT_PROT && so_oe_ff && $changed(pins_s.wp_n)
                              |-> so_ff == prot_ff[sect_ff])
      else $error("protection read follows write-protect pin");

   hw_hold_a: assert property (hw_lock |=> $stable(prot_ff) && $stable(lock_ff))
      else $error("state changed while hardware locked");

   soft_hold_a: assert property (lock_ff |=> $stable(prot_ff))
      else $error("protection changed while lock bit set");

   // a reset also drops the lock and sets every sector, which is not an unlock
   unlock_only_a: assert property (!$past(rst_i) && $fell(lock_ff) |-> $stable(prot_ff))
      else $error("global operation together with unlock");

   reset_state_a: assert property ($past(rst_i) |-> !lock_ff && (&prot_ff))
      else $error("wrong power-up protection state");

   frame_only_a: assert property (!cs_rise |=> $stable(prot_ff))
      else $error("protection changed outside a frame end");

   // status holds zero for the edge that reset is released on
   sum_all_a: assert property (!rst_i && ce_i && (&prot_ff)
                               |=> status_byte_o[STAT_SUM_HI:STAT_SUM_LO] == SUM_ALL)
      else $error("summary does not report all protected");

   sum_none_a: assert property (!rst_i && ce_i && !(|prot_ff)
                                |=> status_byte_o[STAT_SUM_HI:STAT_SUM_LO] == SUM_NONE)
      else $error("summary does not report none protected");

   glob_clear_a: assert property (wsr_go && !lock_ff && glob == GLOB_UNPROT
                                  |=> prot_ff == '0)
      else $error("global unprotect missed");

   lock_set_a: assert property (wsr_go && !lock_ff && wsr_data[STAT_LOCK]
                                |=> lock_ff)
      else $error("lock bit not set by status write");

   soft_clear_a: assert property (wsr_go && lock_ff && pins_s.wp_n && !wsr_data[STAT_LOCK]
                                  |=> !lock_ff)
      else $error("lock bit not cleared under software lock");

   rd_prot_c: cover property (state_ff == SPL_OUT_PROT && so_oe_ff ##1 pins_s.cs_n);
   rd_stat_c: cover property (state_ff == SPL_OUT_STAT && so_oe_ff);
   hw_try_c:  cover property (wsr_go && hw_lock);
   glob_c:    cover property (wsr_go && !lock_ff && glob == GLOB_PROT);
endmodule
`default_nettype wire

// File: verification/spl_host_model.sv
// serial host model that frames commands towards the sector protection lock logic
`default_nettype none
module spl_host_model
   import spl_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // pin timing
   // 80 ns half period keeps us below the no-dummy clock limit
   localparam int HALF = 10;

   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // ==========================================================
   // frame: nb bits out msb first, then nr bits shifted back in
   task automatic xfer(input logic [31:0] tx, input int nb, input int nr,
                       output logic [31:0] rx, output logic oe_ok);
      rx = '0;
      oe_ok = 1'b1;
      cs_n_o <= 1'b0;
      tick(5);
      for (int i = nb - 1; i >= 0; i--) begin
         si_o <= tx[i];
         tick(HALF);
         sck_o <= 1'b1;
         tick(HALF);
         sck_o <= 1'b0;
      end
      for (int j = 0; j < nr; j++) begin
         // si keeps toggling while reading, the device must not care
         si_o <= ~si_o;
         tick(HALF);
         sck_o <= 1'b1;
         rx = {rx[30:0], so_i};
         oe_ok &= so_oe_i;
         tick(HALF);
         sck_o <= 1'b0;
      end
      tick(HALF);
      cs_n_o <= 1'b1;
      tick(HALF);
   endtask

   // two bytes read, the later one is trusted
   task automatic read_prot(input logic [3:0] sect, output logic [7:0] val);
      logic [31:0] rx;
      logic        oe;
      xfer({OP_READ_PROT, 4'h0, sect, 16'ha5c3}, 32, 16, rx, oe);
      val = rx[7:0];
   endtask
endmodule
`default_nettype wire

// File: verification/spl_lock_top_test.sv
// self-checking bench for the sector protection lock logic
`default_nettype none
module spl_lock_top_test
   import spl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic        wp_n_i    = 1'b1;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        so_o;
   logic        so_oe_o;
   logic [7:0]  status_byte_o;
   logic [15:0] prot_bits_o;
   logic        lock_o;
   logic        hw_locked_o;
   wire         so_line;
   int          errors    = 0;
   int          n_checks  = 0;

   assign so_line = so_oe_o ? so_o : 1'bz;

   always #4 clk_sys_i = ~clk_sys_i;

   spl_lock_top spl_lock_top_i (
      .clk_sys_i     (clk_sys_i),
      .rst_i         (rst_i),
      .ce_i          (1'b1),
      .sck_i         (sck),
      .cs_n_i        (cs_n),
      .si_i          (si),
      .wp_n_i        (wp_n_i),
      .so_o          (so_o),
      .so_oe_o       (so_oe_o),
      .status_byte_o (status_byte_o),
      .prot_bits_o   (prot_bits_o),
      .lock_o        (lock_o),
      .hw_locked_o   (hw_locked_o)
   );

   spl_host_model spl_host_model_i (
      .clk_sys_i (clk_sys_i),
      .so_i      (so_line),
      .so_oe_i   (so_oe_o),
      .sck_o     (sck),
      .cs_n_o    (cs_n),
      .si_o      (si)
   );

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   function automatic logic [7:0] exp_stat(input logic lk, input logic wp,
                                           input logic [15:0] p);
      logic [7:0] s;
      s = 8'h00;
      s[STAT_LOCK] = lk;
      s[STAT_WP] = wp;
      s[STAT_SUM_HI:STAT_SUM_LO] = (&p) ? SUM_ALL : ((|p) ? SUM_SOME : SUM_NONE);
      return s;
   endfunction

   task automatic expect_state(input logic [15:0] p, input logic lk);
      check(prot_bits_o, p);
      check(lock_o, lk);
      check(status_byte_o, exp_stat(lk, wp_n_i, p));
   endtask

   task automatic wr_stat(input logic [7:0] b);
      logic [31:0] rx;
      logic        oe;
      spl_host_model_i.xfer({16'h0000, OP_WRITE_STAT, b}, 16, 0, rx, oe);
   endtask

   task automatic sect_cmd(input logic [7:0] op, input logic [3:0] sect);
      logic [31:0] rx;
      logic        oe;
      spl_host_model_i.xfer({op, 4'h0, sect, 16'h5a5a}, 32, 0, rx, oe);
   endtask

   task automatic rd_prot(input logic [3:0] sect, input logic prot);
      logic [7:0] v;
      spl_host_model_i.read_prot(sect, v);
      check(v, prot ? BYTE_ONES : BYTE_ZEROS);
   endtask

   // ==========================================================
   // cut a hang short
   initial begin
      tick(100000);
      errors++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] rx;
      logic        oe;
      tick(2);
      rst_i <= 1'b0;
      tick(4);
      expect_state(16'hffff, 1'b0);
      $display("test reset done");
      rd_prot(4'h3, 1'b1);
      wp_n_i <= 1'b0;
      // pin rises while the first byte is streaming out; the later, checked byte sees it high
      fork
         rd_prot(4'h3, 1'b1);
         begin
            tick(700);
            wp_n_i <= 1'b1;
         end
      join
      sect_cmd(OP_UNPROTECT, 4'h3);
      expect_state(16'hfff7, 1'b0);
      rd_prot(4'h3, 1'b0);
      rd_prot(4'h4, 1'b1);
      spl_host_model_i.xfer({OP_READ_PROT, 24'h03ffff}, 32, 5, rx, oe);
      check(rx, 32'h00000000);
      check(oe, 1'b1);
      check(so_oe_o, 1'b0);
      spl_host_model_i.xfer({24'h000000, OP_READ_STAT}, 8, 16, rx, oe);
      check(rx[7:0], exp_stat(1'b0, 1'b1, 16'hfff7));
      $display("test read done");
      wr_stat(8'h00);
      expect_state(16'h0000, 1'b0);
      wr_stat(8'h04);
      expect_state(16'h0000, 1'b0);
      wr_stat(8'h7f);
      expect_state(16'hffff, 1'b0);
      wr_stat(8'h80);
      expect_state(16'h0000, 1'b1);
      sect_cmd(OP_PROTECT, 4'h2);
      expect_state(16'h0000, 1'b1);
      wr_stat(8'h3c);
      expect_state(16'h0000, 1'b0);
      wr_stat(8'hbc);
      expect_state(16'hffff, 1'b1);
      $display("test soft lock done");
      wp_n_i <= 1'b0;
      tick(6);
      check(hw_locked_o, 1'b1);
      wr_stat(8'h00);
      expect_state(16'hffff, 1'b1);
      sect_cmd(OP_UNPROTECT, 4'h1);
      expect_state(16'hffff, 1'b1);
      wp_n_i <= 1'b1;
      tick(6);
      check(hw_locked_o, 1'b0);
      wr_stat(8'h00);
      expect_state(16'hffff, 1'b0);
      wp_n_i <= 1'b0;
      tick(6);
      check(hw_locked_o, 1'b0);
      sect_cmd(OP_UNPROTECT, 4'h5);
      expect_state(16'hffdf, 1'b0);
      wr_stat(8'h80);
      expect_state(16'h0000, 1'b1);
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      tick(4);
      expect_state(16'hffff, 1'b0);
      $display("test hard lock done");
      print_verdict();
   end
endmodule
`default_nettype wire
